/* verilog/wdc_top.sv */
// Watchdog control, clock selection, restart logic and register slave
//
// Overview of operation
// - Decimal divide: (modulus+1) times decade prescale
// - Watchdog clock from aux, RC or crystal
// - Low select: runs in stop only if kept
// - High select: runs in all stop modes
// - Control register layout at offset 0x0C
// - Window and rate loaded from flash
// - Halt bit: free in special, set-only normally
// - Window/rate writable unmasked; once in normal
// - Normal-mode zero writes change nothing, consume the write
// - Nonzero flash rate starts timeout period
// - Select change, or oscillator loss while on crystal, restarts
// - Normal: accepted nonzero writes, halt rise restart
// - Special: every control write restarts
// - Rate code gives disable or timeout length
// - Timeout asserts system reset
// - Window: early service resets, late accepted
// - Masked write keeps window and rate, not counted
`timescale 1ns/100ps
module wdc_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire wdc_pkg::wdc_av_req_t avReq,
    output wdc_pkg::wdc_av_rsp_t avRsp,
    input wire wdc_pkg::wdc_clk_ticks_t clkTicks,
    input wire wdc_pkg::wdc_sys_status_t sysStatus,
    input wire wdc_pkg::wdc_flash_load_t flashLoad,
    output logic sysResetReq,
    output logic irq
);
    typedef struct packed {
        wdc_pkg::wdc_bus_state_t bus;
        logic [wdc_pkg::AV_DATA_W-1:0] readdata;
        logic windowMode;
        logic debugHalt;
        logic [wdc_pkg::RATE_W-1:0] rate;
        logic writeOnceUsed;
        logic [wdc_pkg::CFG_W-1:0] clkCfg;
        logic [7:0] perCfg;
        logic [wdc_pkg::EVT_W-1:0] evtStatus;
        logic [wdc_pkg::EVT_W-1:0] evtMask;
        logic auxHalf;
        logic oscUpPrev;
        logic restart;
        logic perRestart;
        logic service;
        logic sysReset;
    } wdc_top_state_t;

    localparam wdc_top_state_t ST_RESET = '{
        bus: wdc_pkg::BUS_IDLE,
        readdata: '0,
        windowMode: wdc_pkg::CTL_RESET[wdc_pkg::CTL_WINDOW_BIT],
        debugHalt: wdc_pkg::CTL_RESET[wdc_pkg::CTL_HALT_BIT],
        rate: wdc_pkg::CTL_RESET[wdc_pkg::CTL_RATE_LSB +: wdc_pkg::RATE_W],
        writeOnceUsed: 1'b0,
        clkCfg: wdc_pkg::CFG_RESET,
        perCfg: wdc_pkg::PER_RESET,
        evtStatus: '0,
        evtMask: wdc_pkg::MASK_RESET,
        auxHalf: 1'b0,
        oscUpPrev: 1'b0,
        restart: 1'b0,
        perRestart: 1'b0,
        service: 1'b0,
        sysReset: 1'b0
    };

    wdc_top_state_t st_q;
    wdc_top_state_t st_d;

    logic selLow;
    logic selHigh;
    logic stopKeepsRunning;
    logic wdRun;
    logic wdTick;
    logic forceLongest;
    logic [wdc_pkg::RATE_W-1:0] effRate;
    logic effWindow;
    logic perTick;
    logic perRun;
    logic wdTimeout;
    logic wdViolation;
    logic [wdc_pkg::CNT_W-1:0] wdCount;
    logic perPulse;
    logic accept;
    logic acceptWrite;
    logic [7:0] wByte;

    // Control register image, reserved bits and the mask bit read as zero
    function automatic logic [7:0] controlImage(input wdc_top_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[wdc_pkg::CTL_WINDOW_BIT] = s.windowMode;
        v[wdc_pkg::CTL_HALT_BIT] = s.debugHalt;
        v[wdc_pkg::CTL_RATE_LSB +: wdc_pkg::RATE_W] = s.rate;
        return v;
    endfunction

    function automatic logic [wdc_pkg::AV_DATA_W-1:0] readValue(
            input wdc_top_state_t s,
            input logic [wdc_pkg::AV_ADDR_W-1:0] addr,
            input logic [wdc_pkg::CNT_W-1:0] cnt,
            input logic running);
        logic [wdc_pkg::AV_DATA_W-1:0] v;
        v = '0;
        unique case (addr)
            wdc_pkg::OFS_WD_CONTROL: v[7:0] = controlImage(s);
            wdc_pkg::OFS_CLOCK_CONFIG: v[wdc_pkg::CFG_W-1:0] = s.clkCfg;
            wdc_pkg::OFS_PERIODIC_CONFIG: v[7:0] = s.perCfg;
            wdc_pkg::OFS_EVENT_STATUS: v[wdc_pkg::EVT_W-1:0] = s.evtStatus;
            wdc_pkg::OFS_EVENT_MASK: v[wdc_pkg::EVT_W-1:0] = s.evtMask;
            wdc_pkg::OFS_COUNTER_STATE: v[wdc_pkg::CNT_W:0] = {running, cnt};
            default: v = '0;
        endcase
        return v;
    endfunction

    // Clock source and stop mode behaviour
    always_comb begin
        selLow = st_q.clkCfg[wdc_pkg::CFG_SEL_LOW];
        selHigh = st_q.clkCfg[wdc_pkg::CFG_SEL_HIGH];
        stopKeepsRunning = selHigh
            || (st_q.clkCfg[wdc_pkg::CFG_PSEUDO_STOP] && selLow
                && st_q.clkCfg[wdc_pkg::CFG_KEEP_ALIVE]);
        wdRun = (!sysStatus.stopMode || stopKeepsRunning)
            && !(sysStatus.debugActive && st_q.debugHalt);
        if (selHigh) begin
            wdTick = clkTicks.auxTick && st_q.auxHalf;
        end else if (selLow) begin
            wdTick = clkTicks.oscTick;
        end else begin
            wdTick = clkTicks.rcTick;
        end
        // Special mode debug session without halt runs a nonzero rate at longest, no window
        forceLongest = sysStatus.specialMode && sysStatus.debugActive
            && !st_q.debugHalt && (st_q.rate != 3'h0);
        effRate = forceLongest ? 3'h7 : st_q.rate;
        effWindow = forceLongest ? 1'b0 : st_q.windowMode;
        perTick = st_q.clkCfg[wdc_pkg::CFG_PERIODIC_OSC] ? clkTicks.oscTick : clkTicks.rcTick;
        perRun = (!sysStatus.stopMode
            || (st_q.clkCfg[wdc_pkg::CFG_PSEUDO_STOP]
                && st_q.clkCfg[wdc_pkg::CFG_PERIODIC_OSC]))
            && !(sysStatus.debugActive && st_q.debugHalt);
    end

    // Register slave and control state
    always_comb begin
        accept = (st_q.bus == wdc_pkg::BUS_ACK) && (avReq.read || avReq.write);
        acceptWrite = accept && avReq.write && avReq.byteenable[0];
        wByte = avReq.writedata[7:0];
        st_d = st_q;
        st_d.restart = 1'b0;
        st_d.perRestart = 1'b0;
        st_d.service = 1'b0;
        st_d.oscUpPrev = sysStatus.oscUp;
        if (clkTicks.auxTick) begin
            st_d.auxHalf = !st_q.auxHalf;
        end

        unique case (st_q.bus)
            wdc_pkg::BUS_IDLE: begin
                if (avReq.read || avReq.write) begin
                    st_d.bus = wdc_pkg::BUS_ACK;
                    st_d.readdata = avReq.read
                        ? readValue(st_q, avReq.address, wdCount, wdRun) : '0;
                end
            end
            wdc_pkg::BUS_ACK: begin
                st_d.bus = wdc_pkg::BUS_IDLE;
            end
        endcase

        if (accept && avReq.read && avReq.address == wdc_pkg::OFS_EVENT_STATUS) begin
            st_d.evtStatus = st_q.evtStatus & ~st_q.readdata[wdc_pkg::EVT_W-1:0];
        end

        if (acceptWrite) begin
            unique case (avReq.address)
                wdc_pkg::OFS_WD_CONTROL: begin
                    if (sysStatus.specialMode) begin
                        st_d.debugHalt = wByte[wdc_pkg::CTL_HALT_BIT];
                        st_d.restart = 1'b1;
                        if (!wByte[wdc_pkg::CTL_MASK_BIT]) begin
                            st_d.windowMode = wByte[wdc_pkg::CTL_WINDOW_BIT];
                            st_d.rate = wByte[wdc_pkg::CTL_RATE_LSB +: wdc_pkg::RATE_W];
                        end
                    end else begin
                        if (wByte[wdc_pkg::CTL_HALT_BIT]) begin
                            st_d.debugHalt = 1'b1;
                            if (!st_q.debugHalt) begin
                                st_d.restart = 1'b1;
                            end
                        end
                        if (!wByte[wdc_pkg::CTL_MASK_BIT] && !st_q.writeOnceUsed) begin
                            st_d.writeOnceUsed = 1'b1;
                            if (wByte[wdc_pkg::CTL_WINDOW_BIT]) begin
                                st_d.windowMode = 1'b1;
                                st_d.restart = 1'b1;
                            end
                            if (wByte[wdc_pkg::CTL_RATE_LSB +: wdc_pkg::RATE_W] != 3'h0) begin
                                st_d.rate = wByte[wdc_pkg::CTL_RATE_LSB +: wdc_pkg::RATE_W];
                                st_d.restart = 1'b1;
                            end
                        end
                    end
                end
                wdc_pkg::OFS_CLOCK_CONFIG: begin
                    st_d.clkCfg = wByte[wdc_pkg::CFG_W-1:0];
                    if (wByte[wdc_pkg::CFG_SEL_LOW] != selLow
                        || wByte[wdc_pkg::CFG_SEL_HIGH] != selHigh) begin
                        st_d.restart = 1'b1;
                    end
                    if (wByte[wdc_pkg::CFG_PERIODIC_OSC]
                        != st_q.clkCfg[wdc_pkg::CFG_PERIODIC_OSC]) begin
                        st_d.perRestart = 1'b1;
                    end
                end
                wdc_pkg::OFS_PERIODIC_CONFIG: begin
                    st_d.perCfg = wByte;
                    st_d.perRestart = 1'b1;
                end
                wdc_pkg::OFS_SERVICE: begin
                    st_d.service = 1'b1;
                end
                wdc_pkg::OFS_EVENT_MASK: begin
                    st_d.evtMask = wByte[wdc_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Oscillator loss while the crystal clocks the watchdog
        if (st_q.oscUpPrev && !sysStatus.oscUp && !selHigh && selLow) begin
            st_d.restart = 1'b1;
        end

        // Flash load after reset release takes precedence over a bus write
        if (flashLoad.load) begin
            st_d.windowMode = flashLoad.windowMode;
            st_d.rate = flashLoad.rate;
            if (flashLoad.rate != 3'h0) begin
                st_d.restart = 1'b1;
            end
        end

        // Event set wins over read clear
        st_d.evtStatus[wdc_pkg::EVT_TIMEOUT] = st_d.evtStatus[wdc_pkg::EVT_TIMEOUT] | wdTimeout;
        st_d.evtStatus[wdc_pkg::EVT_WINDOW] = st_d.evtStatus[wdc_pkg::EVT_WINDOW] | wdViolation;
        st_d.evtStatus[wdc_pkg::EVT_PERIODIC] = st_d.evtStatus[wdc_pkg::EVT_PERIODIC] | perPulse;
        st_d.sysReset = wdTimeout || wdViolation;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    wdc_timeout_counter u_counter (
        .core_clk(core_clk),
        .rst(rst),
        .tick(wdTick),
        .run(wdRun),
        .rate(effRate),
        .fromAux(selHigh),
        .windowMode(effWindow),
        .restart(st_q.restart),
        .service(st_q.service),
        .timeout(wdTimeout),
        .windowViolation(wdViolation),
        .count(wdCount)
    );

    wdc_decimal_divider u_divider (
        .core_clk(core_clk),
        .rst(rst),
        .tick(perTick && perRun),
        .enable(st_q.perCfg[wdc_pkg::PER_DECIMAL_BIT]),
        .prescale(st_q.perCfg[wdc_pkg::PER_PRESCALE_LSB +: 3]),
        .modulus(st_q.perCfg[wdc_pkg::PER_MODULUS_LSB +: 4]),
        .restart(st_q.perRestart),
        .periodicPulse(perPulse)
    );

    assign avRsp.readdata = st_q.readdata;
    assign avRsp.waitrequest = (st_q.bus != wdc_pkg::BUS_ACK);
    assign sysResetReq = st_q.sysReset;
    assign irq = |(st_q.evtStatus & st_q.evtMask);
endmodule

/* common/wdc_pkg.sv */
// Shared constants, carriers and lookups of the watchdog control block
package wdc_pkg;

    localparam int AV_ADDR_W = 8;
    localparam int AV_DATA_W = 32;
    localparam int CNT_W = 25;
    localparam int PRE_W = 18;
    localparam int RATE_W = 3;
    localparam int EVT_W = 3;

    // Register byte offsets
    localparam logic [AV_ADDR_W-1:0] OFS_WD_CONTROL = 8'h0C;
    localparam logic [AV_ADDR_W-1:0] OFS_CLOCK_CONFIG = 8'h10;
    localparam logic [AV_ADDR_W-1:0] OFS_PERIODIC_CONFIG = 8'h14;
    localparam logic [AV_ADDR_W-1:0] OFS_SERVICE = 8'h18;
    localparam logic [AV_ADDR_W-1:0] OFS_EVENT_STATUS = 8'h1C;
    localparam logic [AV_ADDR_W-1:0] OFS_EVENT_MASK = 8'h20;
    localparam logic [AV_ADDR_W-1:0] OFS_COUNTER_STATE = 8'h24;

    // Watchdog control fields
    localparam int CTL_WINDOW_BIT = 7;
    localparam int CTL_HALT_BIT = 6;
    localparam int CTL_MASK_BIT = 5;
    localparam int CTL_RATE_LSB = 0;

    // Clock configuration fields
    localparam int CFG_SEL_LOW = 0;
    localparam int CFG_SEL_HIGH = 1;
    localparam int CFG_PSEUDO_STOP = 2;
    localparam int CFG_KEEP_ALIVE = 3;
    localparam int CFG_PERIODIC_OSC = 4;
    localparam int CFG_W = 5;

    // Periodic divider fields
    localparam int PER_DECIMAL_BIT = 7;
    localparam int PER_PRESCALE_LSB = 4;
    localparam int PER_MODULUS_LSB = 0;

    // Event bits
    localparam int EVT_TIMEOUT = 0;
    localparam int EVT_WINDOW = 1;
    localparam int EVT_PERIODIC = 2;

    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
    localparam logic [7:0] PER_RESET = 8'h00;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;

    typedef struct packed {
        logic read;
        logic write;
        logic [AV_ADDR_W-1:0] address;
        logic [AV_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } wdc_av_req_t;

    typedef struct packed {
        logic [AV_DATA_W-1:0] readdata;
        logic waitrequest;
    } wdc_av_rsp_t;

    typedef struct packed {
        logic auxTick;
        logic rcTick;
        logic oscTick;
    } wdc_clk_ticks_t;

    typedef struct packed {
        logic specialMode;
        logic stopMode;
        logic debugActive;
        logic oscUp;
    } wdc_sys_status_t;

    typedef struct packed {
        logic load;
        logic windowMode;
        logic [RATE_W-1:0] rate;
    } wdc_flash_load_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } wdc_bus_state_t;

    // Log2 of the timeout in watchdog clock cycles
    function automatic logic [4:0] timeoutShift(input logic [RATE_W-1:0] rate,
                                                input logic fromAux);
        logic [4:0] s;
        s = 5'h00;
        unique case (rate)
            3'h1: s = fromAux ? 5'h07 : 5'h0E;
            3'h2: s = fromAux ? 5'h09 : 5'h10;
            3'h3: s = fromAux ? 5'h0B : 5'h12;
            3'h4: s = fromAux ? 5'h0D : 5'h14;
            3'h5: s = fromAux ? 5'h0F : 5'h16;
            3'h6: s = fromAux ? 5'h10 : 5'h17;
            3'h7: s = fromAux ? 5'h11 : 5'h18;
            default: s = 5'h00;
        endcase
        return s;
    endfunction

    // Decade prescaler of the periodic divider
    function automatic logic [PRE_W-1:0] decadeCount(input logic [2:0] code);
        logic [PRE_W-1:0] c;
        c = 18'h003E8;
        unique case (code)
            3'h0: c = 18'h003E8;
            3'h1: c = 18'h007D0;
            3'h2: c = 18'h01388;
            3'h3: c = 18'h02710;
            3'h4: c = 18'h04E20;
            3'h5: c = 18'h0C350;
            3'h6: c = 18'h186A0;
            3'h7: c = 18'h30D40;
        endcase
        return c;
    endfunction

endpackage

/* verilog/wdc_timeout_counter.sv */
// Watchdog timeout counter with window check
`timescale 1ns/100ps
module wdc_timeout_counter (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [wdc_pkg::RATE_W-1:0] rate,
    input wire logic fromAux,
    input wire logic windowMode,
    input wire logic restart,
    input wire logic service,
    output logic timeout,
    output logic windowViolation,
    output logic [wdc_pkg::CNT_W-1:0] count
);
    typedef struct packed {
        logic [wdc_pkg::CNT_W-1:0] count;
        logic timeout;
        logic violation;
    } wdc_cnt_state_t;

    wdc_cnt_state_t st_q;
    wdc_cnt_state_t st_d;
    logic [wdc_pkg::CNT_W-1:0] period;
    logic [wdc_pkg::CNT_W-1:0] lastCount;
    logic [wdc_pkg::CNT_W-1:0] windowStart;

    always_comb begin
        period = wdc_pkg::CNT_W'(1) << wdc_pkg::timeoutShift(rate, fromAux);
        lastCount = period - wdc_pkg::CNT_W'(1);
        windowStart = period - (period >> 2);
        st_d = st_q;
        st_d.timeout = 1'b0;
        st_d.violation = 1'b0;
        if (restart || rate == 3'h0) begin
            st_d.count = '0;
        end else if (service) begin
            st_d.violation = windowMode && (st_q.count < windowStart);
            st_d.count = '0;
        end else if (run && tick) begin
            if (st_q.count == lastCount) begin
                st_d.timeout = 1'b1;
                st_d.count = '0;
            end else begin
                st_d.count = st_q.count + wdc_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign timeout = st_q.timeout;
    assign windowViolation = st_q.violation;
    assign count = st_q.count;
endmodule

/* verilog/wdc_decimal_divider.sv */
// Decimal based periodic interrupt divider
`timescale 1ns/100ps
module wdc_decimal_divider (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic enable,
    input wire logic [2:0] prescale,
    input wire logic [3:0] modulus,
    input wire logic restart,
    output logic periodicPulse
);
    typedef struct packed {
        logic [wdc_pkg::PRE_W-1:0] pre;
        logic [3:0] mod;
        logic pulse;
    } wdc_div_state_t;

    wdc_div_state_t st_q;
    wdc_div_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.pulse = 1'b0;
        if (restart || !enable) begin
            st_d.pre = '0;
            st_d.mod = '0;
        end else if (tick) begin
            if (st_q.pre == wdc_pkg::decadeCount(prescale) - wdc_pkg::PRE_W'(1)) begin
                st_d.pre = '0;
                if (st_q.mod == modulus) begin
                    st_d.mod = '0;
                    st_d.pulse = 1'b1;
                end else begin
                    st_d.mod = st_q.mod + 4'h1;
                end
            end else begin
                st_d.pre = st_q.pre + wdc_pkg::PRE_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign periodicPulse = st_q.pulse;
endmodule

/* verif/wdc_props.sv */
// Port checker for the watchdog control block
`timescale 1ns/100ps
module wdc_props (
    input wire logic core_clk,
    input wire logic rst,
    input wire wdc_pkg::wdc_av_req_t avReq,
    input wire wdc_pkg::wdc_av_rsp_t avRsp,
    input wire wdc_pkg::wdc_clk_ticks_t clkTicks,
    input wire logic sysResetReq,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic acc;
    logic anyTick;
    logic [3:0] svcAge_q;
    logic [3:0] svcAge_d;
    assign acc = !avRsp.waitrequest && (avReq.read || avReq.write);
    assign anyTick = |clkTicks;
    // Cycles since the last accepted service write
    always_comb begin
        svcAge_d = (svcAge_q == 4'hF) ? svcAge_q : svcAge_q + 4'h1;
        if (acc && avReq.write && avReq.address == wdc_pkg::OFS_SERVICE) begin
            svcAge_d = 4'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            svcAge_q <= 4'hF;
        end else begin
            svcAge_q <= svcAge_d;
        end
    end
    reset_idle_a: assert property ($fell(rst) |-> avRsp.waitrequest && !sysResetReq && !irq)
        else $error("outputs busy after reset");
    answer_one_a: assert property ($rose(avReq.read || avReq.write) |=> !avRsp.waitrequest)
        else $error("request not answered after one wait cycle");
    wait_one_a: assert property (!avRsp.waitrequest |=> avRsp.waitrequest)
        else $error("waitrequest low for more than one cycle");
    no_stray_a: assert property (!avRsp.waitrequest |-> $past(avReq.read || avReq.write))
        else $error("answer without request");
    ctl_zero_a: assert property (
        acc && avReq.read && avReq.address == wdc_pkg::OFS_WD_CONTROL
        |-> avRsp.readdata[31:8] == 24'h0 && avRsp.readdata[5:3] == 3'h0)
        else $error("control read shows nonzero reserved bits");
    reset_pulse_a: assert property (sysResetReq |=> !sysResetReq)
        else $error("reset request longer than one cycle");
    reset_cause_a: assert property (
        sysResetReq |-> $past(anyTick, 2) || svcAge_q < 4'h8)
        else $error("reset request without tick or service");
    irq_fall_a: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
        else $error("interrupt dropped without access");
endmodule

bind wdc_top wdc_props props (
    .core_clk(core_clk),
    .rst(rst),
    .avReq(avReq),
    .avRsp(avRsp),
    .clkTicks(clkTicks),
    .sysResetReq(sysResetReq),
    .irq(irq)
);

/* verif/testbench.sv */
// Directed register-level bench for the watchdog control block
`timescale 1ns/100ps
module testbench;
    localparam logic [7:0] CTL = wdc_pkg::OFS_WD_CONTROL;
    localparam logic [7:0] CFG = wdc_pkg::OFS_CLOCK_CONFIG;
    localparam logic [7:0] PER = wdc_pkg::OFS_PERIODIC_CONFIG;
    localparam logic [7:0] SVC = wdc_pkg::OFS_SERVICE;
    localparam logic [7:0] EVT = wdc_pkg::OFS_EVENT_STATUS;
    localparam logic [7:0] MSK = wdc_pkg::OFS_EVENT_MASK;
    localparam logic [7:0] CNT = wdc_pkg::OFS_COUNTER_STATE;
    logic core_clk;
    logic rst;
    wdc_pkg::wdc_av_req_t avReq;
    wdc_pkg::wdc_av_rsp_t avRsp;
    wdc_pkg::wdc_clk_ticks_t clkTicks;
    wdc_pkg::wdc_sys_status_t sysStatus;
    wdc_pkg::wdc_flash_load_t flashLoad;
    logic sysResetReq;
    logic irq;
    logic [31:0] d;
    int bad_count = 0;
    int n_checks = 0;
    int hits = 0;
    int h0 = 0;
    int cycles = 0;

    wdc_top DUT (.core_clk(core_clk), .rst(rst), .avReq(avReq), .avRsp(avRsp),
        .clkTicks(clkTicks), .sysStatus(sysStatus), .flashLoad(flashLoad),
        .sysResetReq(sysResetReq), .irq(irq));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset pulses and hang limit
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (sysResetReq === 1'b1) begin
            hits <= hits + 1;
        end
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wrt, input logic [7:0] a, input logic [7:0] v);
        int t;
        t = 0;
        @(posedge core_clk);
        avReq <= '{read: !wrt, write: wrt, address: a, writedata: {24'h0, v},
            byteenable: 4'hF};
        // Hold the request until the edge that samples waitrequest low
        do begin
            @(posedge core_clk);
            t++;
        end while (avRsp.waitrequest !== 1'b0 && t < 50);
        if (t >= 50) begin
            chk("answer", 32'h1, 32'h0);
        end
        d = avRsp.readdata;
        avReq <= '0;
    endtask

    task automatic tk(input logic [2:0] p, input int n);
        repeat (n) begin
            @(posedge core_clk);
            clkTicks <= p;
            @(posedge core_clk);
            clkTicks <= '0;
        end
    endtask

    task automatic rstDut();
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        avReq = '0;
        clkTicks = '0;
        sysStatus = '0;
        flashLoad = '0;
        rstDut();
        bus(0, CTL, 8'h00);
        chk("ctl reset", d, 32'h0);
        @(posedge core_clk);
        flashLoad <= '{load: 1'b1, windowMode: 1'b1, rate: 3'h3};
        @(posedge core_clk);
        flashLoad <= '0;
        bus(0, CTL, 8'h00);
        chk("flash", d, 32'h83);
        tk(3'h2, 2);
        bus(0, CNT, 8'h00);
        chk("flash run", d, 32'h02000002);
        rstDut();
        bus(1, CTL, 8'h25);
        bus(1, CTL, 8'h02);
        bus(0, CTL, 8'h00);
        chk("mask uncounted", d, 32'h02);
        bus(1, CTL, 8'h85);
        bus(0, CTL, 8'h00);
        chk("write once", d, 32'h02);
        tk(3'h2, 3);
        bus(1, CTL, 8'h60);
        bus(0, CNT, 8'h00);
        chk("halt restart", {7'h0, d[24:0]}, 32'h0);
        bus(1, CTL, 8'h20);
        bus(0, CTL, 8'h00);
        chk("halt set only", d, 32'h42);
        sysStatus <= 4'h2;
        tk(3'h2, 2);
        bus(0, CNT, 8'h00);
        chk("debug halt", d, 32'h0);
        sysStatus <= 4'h8;
        bus(1, CTL, 8'h20);
        bus(0, CTL, 8'h00);
        chk("halt special", d, 32'h02);
        bus(1, CTL, 8'h07);
        bus(0, CTL, 8'h00);
        chk("special write", d, 32'h07);
        tk(3'h2, 5);
        bus(0, CNT, 8'h00);
        chk("rc count", {7'h0, d[24:0]}, 32'h5);
        bus(1, CTL, 8'h27);
        tk(3'h1, 3);
        bus(0, CNT, 8'h00);
        chk("special restart", {7'h0, d[24:0]}, 32'h0);
        bus(1, CFG, 8'h01);
        tk(3'h1, 2);
        bus(0, CNT, 8'h00);
        chk("osc count", {7'h0, d[24:0]}, 32'h2);
        sysStatus <= 4'hC;
        tk(3'h1, 3);
        bus(0, CNT, 8'h00);
        chk("stop halt", {7'h0, d[24:0]}, 32'h2);
        bus(1, CFG, 8'h0D);
        tk(3'h1, 3);
        bus(0, CNT, 8'h00);
        chk("pseudo run", {7'h0, d[24:0]}, 32'h5);
        bus(1, CFG, 8'h02);
        bus(0, CNT, 8'h00);
        chk("select restart", {7'h0, d[24:0]}, 32'h0);
        tk(3'h4, 4);
        bus(0, CNT, 8'h00);
        chk("stop aux", {7'h0, d[24:0]}, 32'h2);
        sysStatus <= 4'h9;
        bus(1, CFG, 8'h01);
        tk(3'h1, 2);
        sysStatus <= 4'h8;
        // Loss seen one edge later, reload one edge after that
        @(posedge core_clk);
        bus(0, CNT, 8'h00);
        chk("osc lost", {7'h0, d[24:0]}, 32'h0);
        sysStatus <= '0;
        rstDut();
        bus(1, CTL, 8'h00);
        bus(1, CTL, 8'h82);
        bus(0, CTL, 8'h00);
        chk("zero write", d, 32'h0);
        rstDut();
        bus(1, CFG, 8'h02);
        h0 = hits;
        tk(3'h4, 256);
        bus(1, CTL, 8'h01);
        tk(3'h4, 254);
        chk("no early reset", 32'(hits - h0), 32'h0);
        tk(3'h4, 2);
        repeat (3) @(posedge core_clk);
        chk("timeout", 32'(hits - h0), 32'h1);
        repeat (2) @(negedge core_clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(1, MSK, 8'h01);
        repeat (2) @(negedge core_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        bus(0, EVT, 8'h00);
        chk("timeout event", d & 32'h1, 32'h1);
        repeat (2) @(negedge core_clk);
        chk("irq clear", {31'h0, irq}, 32'h0);
        rstDut();
        bus(1, CFG, 8'h02);
        bus(1, CTL, 8'h81);
        h0 = hits;
        tk(3'h4, 20);
        bus(1, SVC, 8'h00);
        repeat (8) @(posedge core_clk);
        chk("early service", 32'(hits - h0), 32'h1);
        tk(3'h4, 200);
        bus(1, SVC, 8'h00);
        repeat (8) @(posedge core_clk);
        chk("late service", 32'(hits - h0), 32'h1);
        bus(1, PER, 8'h81);
        tk(3'h2, 1999);
        repeat (3) @(posedge core_clk);
        bus(0, EVT, 8'h00);
        chk("period early", d & 32'h4, 32'h0);
        tk(3'h2, 1);
        repeat (3) @(posedge core_clk);
        bus(0, EVT, 8'h00);
        chk("period", d & 32'h4, 32'h4);
        test_done();
    end
endmodule
